// ---- core/sdram_cke_power_state_control.sv ----
/*
  power-state control of the memory device, steered by the clock-enable pin.
  assumes the command pins are synchronous to sys_clk and that the far-end
  controller keeps its own ordering and timing duties.
*/
// Notes on behaviour
// - act on current and previous clock-enable samples
// - current state is state before edge
// - ignore commands while enable stays low
// - enable falls with open rows: active power-down
// - busy entry resolves by banks at completion
// - idle or refreshing entry: precharge power-down
// - no refresh in any power-down
// - self refresh only from idle with refresh
// - termination off in self refresh, no effect
// - idle needs banks closed, quiet, enable high
// - deselect behaves exactly like NOP
`timescale 1ns/100ps
`default_nettype none
module sdram_cke_power_state_control
  import cke_power_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cke_pin,
  input wire command_type command,
  input wire logic [BANK_COUNT-1:0] bank_open,
  input wire activity_type activity,
  input wire logic odt_request,
  output power_status_type status,
  output logic read_allowed,
  output logic write_allowed,
  output power_state_type state
);
  logic cke_now;
  logic cke_prev;
  logic exit_busy;
  logic dll_busy;
  logic write_busy;
  logic load_exit;
  logic load_dll;
  logic load_write;
  logic [9:0] exit_value;
  logic pending_entry;
  power_state_type next_state;

  // nop or deselect both count as no new operation
  function automatic logic is_nop(input command_type c);
    return c.cs_n || ({c.cs_n, c.ras_n, c.cas_n, c.we_n} == CMD_NOP);
  endfunction

  function automatic logic is_refresh(input command_type c);
    return ({c.cs_n, c.ras_n, c.cas_n, c.we_n} == CMD_REFRESH);
  endfunction

  cke_edge_sampler sampler (
    .sys_clk(sys_clk),
    .rst(rst),
    .cke_pin(cke_pin),
    .cke_now(cke_now),
    .cke_prev(cke_prev)
  );

  exit_timer exit_t (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(load_exit),
    .load_value(exit_value),
    .running(exit_busy)
  );

  exit_timer dll_t (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(load_dll),
    .load_value(EXIT_DLL_DELAY),
    .running(dll_busy)
  );

  exit_timer write_t (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(load_write),
    .load_value(WRITE_HOLD_COUNT),
    .running(write_busy)
  );

  logic any_open;
  logic busy_op;
  logic idle_now;
  logic falling;
  logic rising;
  logic stay_low;
  logic illegal;

  assign any_open = |bank_open;
  assign busy_op = activity.busy_burst | activity.busy_precharge;
  // idle: banks closed, no burst, enable high before this edge, timings met
  assign idle_now = !any_open && !activity.busy_burst && !activity.busy_precharge
    && !activity.busy_refresh && !activity.timing_pending && cke_prev
    && !exit_busy;
  // decide from current and previous enable samples
  assign falling = cke_prev && !cke_now;
  assign rising = !cke_prev && cke_now;
  assign stay_low = !cke_prev && !cke_now;

  // transition from the state held before this edge
  always_comb begin
    next_state = state;
    load_exit = 1'b0;
    load_dll = 1'b0;
    load_write = 1'b0;
    exit_value = EXIT_PD_DELAY;
    illegal = 1'b0;
    case (state)
      ST_IDLE, ST_ACTIVE: begin
        if (falling && is_refresh(command) && idle_now) begin
          next_state = ST_SELF_REFRESH;
        end else if (falling && is_nop(command)) begin
          if (any_open && !busy_op) begin
            next_state = ST_ACTIVE_PD;
          end else if (busy_op) begin
            next_state = ST_ACTIVE_PD;
          end else begin
            next_state = ST_PRECHARGE_PD;
          end
        end else if (falling) begin
          illegal = 1'b1;
        end else if (any_open || busy_op) begin
          next_state = ST_ACTIVE;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_ACTIVE_PD, ST_PRECHARGE_PD: begin
        // command pins are not looked at while enable stays low
        if (stay_low) begin
          next_state = state;
        end else if (rising && is_nop(command)) begin
          next_state = ST_EXITING;
          load_exit = 1'b1;
          exit_value = EXIT_PD_DELAY;
        end else if (rising) begin
          illegal = 1'b1;
        end
      end
      ST_SELF_REFRESH: begin
        if (stay_low) begin
          next_state = state;
        end else if (rising && is_nop(command)) begin
          next_state = ST_EXITING;
          load_exit = 1'b1;
          exit_value = EXIT_SELF_DELAY;
          load_dll = 1'b1;
          load_write = 1'b1;
        end else if (rising) begin
          illegal = 1'b1;
        end
      end
      ST_EXITING: begin
        if (!exit_busy) begin
          next_state = any_open ? ST_ACTIVE : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // power-down entered mid operation resolves once that operation finishes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_entry <= 1'b0;
    end else if ((state == ST_IDLE || state == ST_ACTIVE) && next_state == ST_ACTIVE_PD
        && busy_op) begin
      pending_entry <= 1'b1;
    end else if (state != ST_ACTIVE_PD) begin
      // held for the whole power-down so the resolved kind stays shown
      pending_entry <= 1'b0;
    end
  end

  power_state_type resolved_state;
  always_comb begin
    resolved_state = state;
    if (pending_entry && !busy_op && state == ST_ACTIVE_PD && !any_open) begin
      resolved_state = ST_PRECHARGE_PD;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status.active_pd <= (next_state == ST_ACTIVE_PD) && !(resolved_state == ST_PRECHARGE_PD);
      status.precharge_pd <= (next_state == ST_PRECHARGE_PD)
        || (resolved_state == ST_PRECHARGE_PD && next_state == ST_ACTIVE_PD);
      status.self_refresh <= (next_state == ST_SELF_REFRESH);
      status.idle <= (next_state == ST_IDLE) && idle_now;
      // no internal refresh while powered down
      status.refresh_enable <= (next_state == ST_SELF_REFRESH);
      // termination off throughout self refresh; its request never steers state
      status.odt_enable <= odt_request && (next_state != ST_SELF_REFRESH)
        && !dll_busy;
      status.command_accept <= (next_state == ST_IDLE || next_state == ST_ACTIVE)
        && cke_now;
      status.illegal_sequence <= illegal;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      read_allowed <= 1'b0;
      write_allowed <= 1'b0;
    end else begin
      read_allowed <= (next_state == ST_IDLE || next_state == ST_ACTIVE) && !dll_busy;
      write_allowed <= (next_state == ST_IDLE || next_state == ST_ACTIVE)
        && !write_busy;
    end
  end
endmodule
`default_nettype wire

// ---- inc/cke_power_pkg.sv ----
/*
  constants, state codes and carrier structs for the clock-enable power-state block.
  assumes a single 125 MHz system clock; no registers reached by software.
*/
package cke_power_pkg;
  localparam int unsigned BANK_COUNT = 8;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // write-leveling and first-write hold-off after self-refresh exit, in clocks
  localparam int unsigned SRX_WRITE_HOLD_NCK = 512;
  // exit delays in clocks, plain defaults
  localparam logic [9:0] EXIT_SELF_DELAY = 10'h080;
  localparam logic [9:0] EXIT_DLL_DELAY = 10'h200;
  localparam logic [9:0] EXIT_PD_DELAY = 10'h003;
  localparam logic [9:0] WRITE_HOLD_COUNT = 10'(SRX_WRITE_HOLD_NCK);
  localparam logic [9:0] COUNT_ZERO = 10'h000;
  localparam logic [9:0] COUNT_ONE = 10'h001;

  // command codes on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_MODE_SET = 4'h0;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  localparam int unsigned CS_BIT = 3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ACTIVE = 6'h02,
    ST_ACTIVE_PD = 6'h04,
    ST_PRECHARGE_PD = 6'h08,
    ST_SELF_REFRESH = 6'h10,
    ST_EXITING = 6'h20
  } power_state_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } command_type;

  typedef struct packed {
    logic busy_burst;
    logic busy_refresh;
    logic busy_precharge;
    logic timing_pending;
  } activity_type;

  typedef struct packed {
    logic active_pd;
    logic precharge_pd;
    logic self_refresh;
    logic idle;
    logic refresh_enable;
    logic odt_enable;
    logic command_accept;
    logic illegal_sequence;
  } power_status_type;
endpackage

// ---- core/cke_edge_sampler.sv ----
/*
  samples the clock-enable pin through three flip-flops and reports the
  agreed level now and at the previous edge.
  assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module cke_edge_sampler
  import cke_power_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cke_pin,
  output logic cke_now,
  output logic cke_prev
);
  logic sync_a;
  logic sync_b;
  logic sync_c;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= cke_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // level moves only once second and third stages agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cke_now <= 1'b0;
      cke_prev <= 1'b0;
    end else begin
      if (sync_b == sync_c) begin
        cke_now <= sync_c;
      end
      cke_prev <= cke_now;
    end
  end
endmodule
`default_nettype wire

// ---- core/exit_timer.sv ----
/*
  down counter for exit and hold-off delays.
  assumes load pulses come from the power-state logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module exit_timer
  import cke_power_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [9:0] load_value,
  output logic running
);
  logic [9:0] count;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= COUNT_ZERO;
    end else if (load) begin
      count <= load_value;
    end else if (count != COUNT_ZERO) begin
      count <= count - COUNT_ONE;
    end
  end

  assign running = (count != COUNT_ZERO);
endmodule
`default_nettype wire

// ---- sim/cke_power_assertions.sv ----
/*
  assertions on the power-state ports.
  assumes one rising-edge clock and synchronous rst.
*/
`timescale 1ns/100ps
`default_nettype none
module cke_power_assertions
  import cke_power_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cke_pin,
  input wire power_status_type status,
  input wire logic read_allowed,
  input wire logic write_allowed,
  input wire power_state_type state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic pd;
  logic sr_seen;
  logic [9:0] since_sr;
  assign pd = (state == ST_ACTIVE_PD) || (state == ST_PRECHARGE_PD);
  // cycles since self refresh was last held
  always_ff @(posedge sys_clk) begin
    if (rst || state == ST_SELF_REFRESH) begin
      since_sr <= COUNT_ZERO;
    end else if (since_sr != 10'h3FF) begin
      since_sr <= since_sr + COUNT_ONE;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sr_seen <= 1'b0;
    end else if (state == ST_SELF_REFRESH) begin
      sr_seen <= 1'b1;
    end
  end
  property p_pd_no_refresh; pd |-> !status.refresh_enable; endproperty
  a_pd_no_refresh: assert property (p_pd_no_refresh)
    else $error("refresh in power-down");
  property p_sr_status;
    state == ST_SELF_REFRESH |-> status.self_refresh && !status.odt_enable;
  endproperty
  a_sr_status: assert property (p_sr_status)
    else $error("self refresh status or termination wrong");
  property p_sr_entry; $rose(state == ST_SELF_REFRESH) |-> $past(state) == ST_IDLE; endproperty
  a_sr_entry: assert property (p_sr_entry)
    else $error("self refresh entered from non-idle");
  property p_sr_exit; $fell(state == ST_SELF_REFRESH) |-> (state == ST_EXITING) [*8]; endproperty
  a_sr_exit: assert property (p_sr_exit)
    else $error("self refresh exit too short");
  property p_read_hold; $fell(state == ST_SELF_REFRESH) |-> (!read_allowed) [*8]; endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read allowed early");
  property p_write_hold; write_allowed && sr_seen |-> since_sr >= 10'h1FC; endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("write allowed early");
  property p_pd_hold; (!cke_pin) [*6] ##0 pd |=> pd; endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("power-down left with enable low");
  property p_illegal; status.illegal_sequence |-> $stable(state) ##1 !status.illegal_sequence;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal flag wrong");
  c_apd: cover property (state == ST_ACTIVE_PD);
  c_sr: cover property (state == ST_SELF_REFRESH);
  c_ill: cover property (status.illegal_sequence);
endmodule
bind sdram_cke_power_state_control cke_power_assertions chk (
  .sys_clk, .rst, .cke_pin, .status, .read_allowed, .write_allowed, .state
);
`default_nettype wire

// ---- sim/ctrl_model.sv ----
/*
  far-end controller model for clock-enable and command pins.
  assumes tasks are called by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module ctrl_model
  import cke_power_pkg::*;
(
  input wire logic sys_clk,
  output logic cke_pin,
  output command_type command
);
  initial begin
    cke_pin = 1'b1;
    command = CMD_NOP;
  end
  // lower enable with cmd past the synchroniser, then step the command pins through codes 0 to 5
  task automatic enter(input logic [3:0] cmd);
    @(posedge sys_clk);
    cke_pin <= 1'b0;
    command <= cmd;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      command <= command_type'(i[3:0]);
      @(posedge sys_clk);
    end
    command <= CMD_NOP;
    repeat (2) @(posedge sys_clk);
  endtask
  // raise enable with NOP and keep NOP
  task automatic leave();
    @(posedge sys_clk);
    cke_pin <= 1'b1;
    command <= CMD_NOP;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- sim/sdram_cke_power_state_control_bench.sv ----
/*
  self-checking bench for the power-state block.
  assumes the controller model drives enable and command.
*/
`timescale 1ns/100ps
`default_nettype none
module sdram_cke_power_state_control_bench;
  import cke_power_pkg::*;
  logic sys_clk, rst, cke_pin, odt_request, read_allowed, write_allowed;
  command_type command;
  logic [BANK_COUNT-1:0] bank_open;
  activity_type activity;
  power_status_type status;
  power_state_type state;
  int num_errors = 0;
  int samples_checked = 0;
  int illegal_seen = 0;
  ctrl_model ctrl (.sys_clk(sys_clk), .cke_pin(cke_pin), .command(command));
  sdram_cke_power_state_control dut (.sys_clk(sys_clk), .rst(rst), .cke_pin(cke_pin),
    .command(command), .bank_open(bank_open), .activity(activity),
    .odt_request(odt_request), .status(status), .read_allowed(read_allowed),
    .write_allowed(write_allowed), .state(state));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (status.illegal_sequence === 1'b1) illegal_seen++;
  task automatic wrap_up();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_state(input power_state_type got, input power_state_type exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_state(input power_state_type exp);
    int n;
    for (n = 0; n < 800 && state !== exp; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk_state(state, exp);
    if (state !== exp) wrap_up();
  endtask
  task automatic sc_reset();
    @(posedge sys_clk);
    #1;
    chk_state(state, ST_IDLE);
    chk_bit(status === '0, 1'b1);
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic sc_active_pd();
    bank_open <= 8'h01;
    wait_state(ST_ACTIVE);
    ctrl.enter(CMD_NOP);
    #1;
    chk_state(state, ST_ACTIVE_PD);
    chk_bit(status.active_pd, 1'b1);
    chk_bit(status.refresh_enable, 1'b0);
    ctrl.leave();
    wait_state(ST_ACTIVE);
    @(posedge sys_clk);
    bank_open <= 8'h00;
    wait_state(ST_IDLE);
    chk_bit(status.idle, 1'b1);
  endtask
  task automatic sc_pre_pd(input logic [3:0] cmd);
    ctrl.enter(cmd);
    #1;
    chk_state(state, ST_PRECHARGE_PD);
    chk_bit(status.precharge_pd, 1'b1);
    ctrl.leave();
    wait_state(ST_IDLE);
  endtask
  task automatic sc_busy_pd();
    @(posedge sys_clk);
    activity <= 4'h8;
    ctrl.enter(CMD_NOP);
    #1;
    chk_state(state, ST_ACTIVE_PD);
    chk_bit(status.precharge_pd, 1'b0);
    @(posedge sys_clk);
    activity <= 4'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit(status.precharge_pd, 1'b1);
    ctrl.leave();
    wait_state(ST_IDLE);
  endtask
  task automatic sc_self_refresh();
    @(posedge sys_clk);
    odt_request <= 1'b1;
    ctrl.enter(CMD_REFRESH);
    #1;
    chk_state(state, ST_SELF_REFRESH);
    chk_bit(status.refresh_enable, 1'b1);
    chk_bit(status.self_refresh, 1'b1);
    chk_bit(status.command_accept, 1'b0);
    chk_bit(status.odt_enable, 1'b0);
    ctrl.leave();
    #1;
    chk_state(state, ST_EXITING);
    chk_bit(read_allowed, 1'b0);
    wait_state(ST_IDLE);
    chk_bit(write_allowed, 1'b0);
    repeat (420) @(posedge sys_clk);
    #1;
    chk_bit(write_allowed, 1'b1);
    chk_bit(read_allowed, 1'b1);
    chk_bit(status.odt_enable, 1'b1);
  endtask
  task automatic sc_illegal();
    chk_bit(illegal_seen == 0, 1'b1);
    ctrl.enter(CMD_READ);
    chk_bit(illegal_seen != 0, 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    odt_request = 1'b0;
    bank_open = '0;
    activity = '0;
    sc_reset();
    sc_active_pd();
    sc_pre_pd(CMD_NOP);
    sc_pre_pd(4'hF);
    sc_busy_pd();
    sc_self_refresh();
    sc_illegal();
    wrap_up();
  end
endmodule
`default_nettype wire
